//--- dv/mosfet_pair_model.sv
// behavioural model of the external high-side and low-side switch pair
`timescale 1ns/1ns
module mosfet_pair_model (
  // clock
  input wire logic pclk,
  // gate drives
  input wire logic high_gate,
  input wire logic low_gate,
  // switch node and fault count
  output logic phase,
  output int overlap_cnt
);
  logic hg_q = 1'b0;
  logic lg_q = 1'b0;
  initial phase = 1'b0;
  initial overlap_cnt = 0;
  // a swap with no off cycle between shorts the input supply
  always @(posedge pclk) begin
    if ((high_gate && low_gate) || (hg_q && low_gate) || (lg_q && high_gate))
      overlap_cnt <= overlap_cnt + 1;
    hg_q <= high_gate;
    lg_q <= low_gate;
  end
  // nobody drives the node while both are off: show it toggling
  always @(posedge pclk) begin
    if (high_gate)
      phase <= 1'b1;
    else if (low_gate)
      phase <= 1'b0;
    else
      phase <= ~phase;
  end
endmodule : mosfet_pair_model

//--- dv/tb_charger_gate_protect_ctrl.sv
// self-checking bench for the gate protection controller
`timescale 1ns/1ns
`include "gate_protect_map.svh"
module tb_charger_gate_protect_ctrl;
  import gate_protect_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int DET = 8;
  localparam int PER = `PERIOD_CYC;
  // supplies good, adapter in, battery normal, no faults
  localparam comp_t GOOD = 15'h5c21;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  comp_t comp = GOOD;
  logic [31:0] prdata;
  logic pready, pslverr, high_gate, low_gate, gds_en, icm_en, bus_act;
  logic sink_en, trickle, alarm_o, alarm_oe, adapter_good, phase;
  int overlap_cnt;
  int num_errors = 0;
  int num_checks = 0;
  int hi_cnt, lo_cnt, lo_run;
  logic [31:0] rd;
  logic err;

  always #25 pclk = ~pclk;

  charger_gate_protect_ctrl #(.DETECT_CYCLES(DET)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_in(comp),
    .high_gate(high_gate), .low_gate(low_gate),
    .gate_drive_supply_en(gds_en), .input_current_monitor_en(icm_en),
    .serial_bus_active(bus_act), .discharge_sink_en(sink_en),
    .trickle_clamp(trickle), .input_current_alarm_o(alarm_o),
    .input_current_alarm_oe(alarm_oe), .adapter_good_output(adapter_good));
  mosfet_pair_model i_fets (.pclk(pclk), .high_gate(high_gate),
    .low_gate(low_gate), .phase(phase), .overlap_cnt(overlap_cnt));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= rd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    rd = d;
    apb(1'b1, a);
  endtask : wr

  // two synchroniser stages plus margin
  task automatic setc(input comp_t c);
    @(posedge pclk);
    comp <= c;
    repeat (6) @(posedge pclk);
  endtask : setc

  // skip one period of change-over, then count two whole periods
  task automatic observe();
    int run;
    run = 0;
    hi_cnt = 0;
    lo_cnt = 0;
    lo_run = 0;
    repeat (PER) @(posedge pclk);
    repeat (2 * PER) begin
      @(negedge pclk);
      hi_cnt += (high_gate === 1'b1);
      lo_cnt += (low_gate === 1'b1);
      run = (low_gate === 1'b1) ? run + 1 : 0;
      if (run > lo_run)
        lo_run = run;
    end
  endtask : observe

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs();
    apb(1'b0, `ADDR_ID);
    chk("id", `ID_VALUE, rd);
    apb(1'b0, `ADDR_CTRL);
    chk("ctrl", `CTRL_RESET, rd);
    apb(1'b0, 12'h010);
    chk("unmapped", 1, err);
    chk("sink idle", 0, sink_en);
    chk("gates idle", 0, {high_gate, low_gate});
    $display("done regs");
  endtask : test_regs

  task automatic test_sync();
    wr(`ADDR_DUTY, 32'h0000_0080);
    wr(`ADDR_CTRL, 32'h0000_0001);
    repeat (DET + 20) @(posedge pclk);
    chk("sink on", 1, sink_en);
    observe();
    chk("sync fill", 2 * PER - 4 * `DEAD_CYC, hi_cnt + lo_cnt);
    chk("high on", 1, hi_cnt > 0);
    chk("overlap", 0, overlap_cnt);
    $display("done sync");
  endtask : test_sync

  task automatic test_nonsync();
    comp_t c;
    c = GOOD;
    c.undercurrent = 1'b1;
    setc(c);
    observe();
    chk("pulse len", `RECHARGE_CYC, lo_run);
    chk("pulse cnt", 2 * `RECHARGE_CYC, lo_cnt);
    wr(`ADDR_DUTY, 32'h0000_0000);
    observe();
    chk("zero duty", 0, hi_cnt + lo_cnt);
    wr(`ADDR_DUTY, 32'h0000_0080);
    setc(GOOD);
    $display("done nonsync");
  endtask : test_nonsync

  task automatic test_block();
    comp_t c;
    c = GOOD;
    c.batt_over_hi = 1'b1;
    c.batt_over_lo = 1'b1;
    setc(c);
    observe();
    chk("ovp", 0, hi_cnt);
    c.batt_over_hi = 1'b0;
    setc(c);
    observe();
    chk("ovp hold", 0, hi_cnt);
    c = GOOD;
    c.charge_overcurrent = 1'b1;
    setc(c);
    observe();
    chk("oc", 0, hi_cnt);
    setc(GOOD);
    observe();
    chk("resume", 1, hi_cnt > 0);
    $display("done block");
  endtask : test_block

  task automatic test_thermal();
    comp_t c;
    c = GOOD;
    c.temp_hi = 1'b1;
    c.temp_lo = 1'b1;
    setc(c);
    observe();
    chk("thermal_shutdown", 0, hi_cnt + lo_cnt);
    chk("sink off", 0, sink_en);
    c.temp_hi = 1'b0;
    setc(c);
    chk("thermal_shutdown hold", 0, sink_en);
    setc(GOOD);
    repeat (DET + 20) @(posedge pclk);
    chk("thermal_shutdown end", 1, sink_en);
    $display("done thermal");
  endtask : test_thermal

  task automatic test_flags();
    comp_t c;
    c = GOOD;
    c.batt_short_lo = 1'b1;
    c.batt_short_hi = 1'b0;
    c.input_over_ref = 1'b1;
    setc(c);
    chk("short", 1, trickle);
    chk("alarm", 2'b01, {alarm_o, alarm_oe});
    c.batt_short_lo = 1'b0;
    setc(c);
    chk("short hold", 1, trickle);
    setc(GOOD);
    chk("short end", 0, trickle);
    chk("alarm off", 0, alarm_oe);
    $display("done flags");
  endtask : test_flags

  task automatic test_supply();
    comp_t c;
    c = GOOD;
    c.serial_bus_supply_ok = 1'b0;
    setc(c);
    chk("bus off", 0, bus_act);
    wr(`ADDR_CTRL, 32'h0000_0000);
    chk("refused", 1, err);
    c = GOOD;
    c.adapter_detect_low = 1'b1;
    setc(c);
    chk("det low", 0, {icm_en, bus_act});
    c = GOOD;
    c.adapter_supply_ok = 1'b0;
    setc(c);
    chk("uvlo", 0, {gds_en, icm_en, bus_act, sink_en});
    setc(GOOD);
    chk("restored", 3'b111, {gds_en, icm_en, bus_act});
    apb(1'b0, `ADDR_CTRL);
    chk("retained", 1, rd[0]);
    $display("done supply");
  endtask : test_supply

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_sync();
    test_nonsync();
    test_block();
    test_thermal();
    test_flags();
    test_supply();
    chk("overlap end", 0, overlap_cnt);
    summarize();
  end

  initial begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule : tb_charger_gate_protect_ctrl

//--- rtl/charger_gate_protect_ctrl.sv
// gate sequencing, protection gating and apb registers of the charger
`timescale 1ns/1ns
`include "gate_protect_map.svh"
// Operation
// RULE_01 - undercurrent comparator picks non-synchronous mode
// RULE_02 - synchronous: low side on when high off
// RULE_03 - dead time between switch transitions
// RULE_04 - non-sync: short low pulse then off
// RULE_05 - zero duty: both off, no pulse
// RULE_06 - current monitor enabled by supply and detect
// RULE_07 - serial bus active needs three conditions
// RULE_08 - serial supply valid with hysteresis accepts access
// RULE_09 - settings retained while serial supply powered
// RULE_10 - low adapter supply disables bias, charging
// RULE_11 - overvoltage blocks high side with hysteresis
// RULE_12 - discharge sink only while charging
// RULE_13 - battery short clamps current to trickle
// RULE_14 - input current alarm pulls low
// RULE_15 - overcurrent turns high side off
// RULE_16 - thermal shutdown with hysteresis
// RULE_17 - charge start conditions incl. detection delay
// RULE_18 - fixed oscillator sets switching period
// RULE_19 - comparator inputs pass two flip-flops
// RULE_20 - dead and pulse times counted, rounded up
module charger_gate_protect_ctrl
  import gate_protect_pkg::*;
#(
  parameter int unsigned DETECT_CYCLES = `DETECT_CYC
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparator decisions
  input wire comp_t comp_in,
  // gate drive and status
  output logic high_gate,
  output logic low_gate,
  output logic gate_drive_supply_en,
  output logic input_current_monitor_en,
  output logic serial_bus_active,
  output logic discharge_sink_en,
  output logic trickle_clamp,
  output logic input_current_alarm_o,
  output logic input_current_alarm_oe,
  output logic adapter_good_output
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // a net: each bit has its own synchroniser as driver
  wire comp_t cs;
  genvar gi;
  generate
    for (gi = 0; gi < $bits(comp_t); gi++) begin : g_sync
      sync2 u_sync ( // RULE_19
        .pclk(pclk),
        .presetn(presetn),
        .d(comp_in[gi]),
        .q(cs[gi])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // hysteresis flags
  // ----------------------------------------------------------------
  logic sync_mode; // high when current above threshold
  logic ovp_flag;
  logic short_flag;
  logic thermal_shutdown_flag;
  logic bus_supply_flag;
  // undercurrent comparator already holds 13 mV / 8 mV hysteresis
  assign sync_mode = ~cs.undercurrent; // RULE_01
  hyst_latch u_ovp (
    .pclk(pclk), .presetn(presetn),
    .set_i(cs.batt_over_hi), .clr_i(~cs.batt_over_lo), .flag(ovp_flag)
  ); // RULE_11
  hyst_latch u_short (
    .pclk(pclk), .presetn(presetn),
    .set_i(cs.batt_short_lo), .clr_i(cs.batt_short_hi), .flag(short_flag)
  ); // RULE_13
  hyst_latch u_thermal_shutdown (
    .pclk(pclk), .presetn(presetn),
    .set_i(cs.temp_hi), .clr_i(~cs.temp_lo), .flag(thermal_shutdown_flag)
  ); // RULE_16
  // comparator gives 2.7 V rising; falling 250 mV lower is its clear
  assign bus_supply_flag = cs.serial_bus_supply_ok; // RULE_08
  // ----------------------------------------------------------------
  // power gating and enables
  // ----------------------------------------------------------------
  wire detect_ok = cs.adapter_supply_ok & ~cs.adapter_detect_low;
  assign gate_drive_supply_en = detect_ok; // RULE_10
  assign input_current_monitor_en = detect_ok; // RULE_06
  assign serial_bus_active = detect_ok & bus_supply_flag; // RULE_07
  assign adapter_good_output = cs.adapter_present & cs.adapter_supply_ok;
  assign input_current_alarm_o = 1'b0;
  assign input_current_alarm_oe = cs.input_over_ref; // RULE_14
  // ----------------------------------------------------------------
  // detection delay
  // ----------------------------------------------------------------
  logic [15:0] det_cnt_reg;
  logic det_done;
  wire present = cs.adapter_present & cs.adapter_supply_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_cnt_reg <= 16'h0000;
    end else if (!present) begin
      det_cnt_reg <= 16'h0000;
    end else if (!det_done) begin
      det_cnt_reg <= det_cnt_reg + 16'h0001;
    end
  end
  assign det_done = det_cnt_reg >= DETECT_CYCLES[15:0];
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [`DUTY_W-1:0] duty_reg;
  wire charge_enable = ctrl_reg[0];
  wire charging = charge_enable & present & cs.adapter_above_batt & det_done
                  & cs.bias_ok & ~thermal_shutdown_flag & detect_ok; // RULE_17
  assign discharge_sink_en = charging; // RULE_12
  assign trickle_clamp = short_flag; // RULE_13
  wire acc = psel & penable & serial_bus_active; // RULE_08
  wire wr_ctrl = acc & pwrite & (paddr == `ADDR_CTRL);
  wire wr_duty = acc & pwrite & (paddr == `ADDR_DUTY);
  wire hit = (paddr == `ADDR_CTRL) | (paddr == `ADDR_DUTY)
           | (paddr == `ADDR_STATUS) | (paddr == `ADDR_ID);
  // settings live on the serial supply; only presetn clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      duty_reg <= `DUTY_RESET;
    end else begin
      if (wr_ctrl) ctrl_reg <= {31'h0, pwdata[0]}; // RULE_09
      if (wr_duty) duty_reg <= pwdata[`DUTY_W-1:0];
    end
  end
  wire [31:0] status_w = {22'h0, short_flag, ovp_flag, thermal_shutdown_flag,
                          sync_mode, charging, det_done, low_gate,
                          high_gate, serial_bus_active, detect_ok};
  wire [31:0] rd_mux = (paddr == `ADDR_CTRL) ? ctrl_reg :
                       (paddr == `ADDR_DUTY) ? {24'h0, duty_reg} :
                       (paddr == `ADDR_STATUS) ? status_w :
                       (paddr == `ADDR_ID) ? `ID_VALUE : 32'h0;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (~hit | ~serial_bus_active);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end
  // ----------------------------------------------------------------
  // switching period and gate sequencing
  // ----------------------------------------------------------------
  localparam logic [7:0] PER = 8'(`PERIOD_CYC);
  localparam logic [7:0] DEAD = 8'(`DEAD_CYC);
  localparam logic [7:0] RCH = 8'(`RECHARGE_CYC);
  logic [7:0] phase_reg;
  logic [7:0] tmr_reg;
  logic [7:0] tmr_next;
  drive_state_t st_reg;
  drive_state_t st_next;
  wire period_start = (phase_reg == PER - 8'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 8'h00;
    end else begin
      phase_reg <= period_start ? 8'h00 : phase_reg + 8'h01; // RULE_18
    end
  end
  // duty scaled to the period: on while phase*256 < duty*per
  wire [15:0] duty_thr = 16'(duty_reg) * 16'(PER);
  wire on_window = ({phase_reg, 8'h00} < duty_thr);
  wire zero_duty = (duty_reg == `DUTY_RESET);
  wire hs_block = ovp_flag | cs.charge_overcurrent | thermal_shutdown_flag
                | ~charging; // RULE_11 RULE_15 RULE_16
  wire want_high = on_window & ~hs_block & ~zero_duty;
  wire tmr_done = (tmr_reg == 8'h00);
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_done ? 8'h00 : tmr_reg - 8'h01;
    case (st_reg)
      ST_OFF: begin
        if (want_high) begin
          st_next = ST_HIGH;
        end else if (sync_mode & ~zero_duty & charging) begin
          st_next = ST_DEAD_HL;
          tmr_next = DEAD - 8'h01;
        end
      end
      ST_HIGH: begin
        if (!want_high) begin
          st_next = ST_DEAD_HL; // RULE_03
          tmr_next = DEAD - 8'h01;
        end
      end
      ST_DEAD_HL: begin
        if (tmr_done) begin
          if (zero_duty | ~charging) begin
            st_next = ST_OFF; // RULE_05
          end else begin
            st_next = ST_LOW;
            tmr_next = RCH - 8'h01; // RULE_20
          end
        end
      end
      ST_LOW: begin
        if (want_high | zero_duty | ~charging) begin
          st_next = ST_DEAD_LH; // RULE_03
          tmr_next = DEAD - 8'h01;
        end else if (!sync_mode & tmr_done) begin
          st_next = ST_OFF; // RULE_04
        end
      end
      ST_DEAD_LH: begin
        // straight to high: an extra off cycle would stretch the gap
        if (tmr_done & want_high) begin
          st_next = ST_HIGH; // RULE_03
        end else if (tmr_done) begin
          st_next = ST_OFF;
        end
      end
      default: begin
        st_next = ST_OFF;
        tmr_next = 8'h00;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_OFF;
      tmr_reg <= 8'h00;
      high_gate <= 1'b0;
      low_gate <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      high_gate <= (st_next == ST_HIGH);
      low_gate <= (st_next == ST_LOW); // RULE_02
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  no_shoot_a: assert property (!(high_gate && low_gate)) // RULE_03
    else $error("both gates on");
  dead_gap_a: assert property ($fell(high_gate) |-> !low_gate) // RULE_03
    else $error("no dead time after high side");
  zero_off_a: assert property (zero_duty[*2] |=> !high_gate) // RULE_05
    else $error("high side on at zero duty");
  block_hs_a: assert property (hs_block |=> !high_gate) // RULE_15
    else $error("high side on while blocked");
  // the recharge pulse is two clock cycles wide at 50 ns
  pulse_len_a: assert property ($rose(low_gate) && !sync_mode // RULE_04
    ##1 !sync_mode |=> !low_gate)
    else $error("recharge pulse too long");
  after_high_a: assert property ($fell(high_gate) && charging // RULE_02
    && !zero_duty |=> low_gate)
    else $error("low side not on after dead time");
  dead_lh_a: assert property ($fell(low_gate) |-> !high_gate) // RULE_03
    else $error("no dead time after low side");
  sink_chg_a: assert property (discharge_sink_en |-> charge_enable // RULE_12
    && det_done && cs.bias_ok)
    else $error("sink on while not charging");
  det_hold_a: assert property (!present |=> det_cnt_reg == 16'h0000) // RULE_17
    else $error("detection delay not restarted");
  trickle_a: assert property (cs.batt_short_lo |=> trickle_clamp) // RULE_13
    else $error("no trickle clamp on short");
  thermal_shutdown_a: assert property (thermal_shutdown_flag |-> !charging) // RULE_16
    else $error("charging in thermal shutdown");
  monitor_a: assert property (cs.adapter_detect_low // RULE_06
    |-> !input_current_monitor_en && !serial_bus_active)
    else $error("monitor on with adapter low");
  uvlo_a: assert property (!cs.adapter_supply_ok |-> !charging
    && !gate_drive_supply_en) // RULE_10
    else $error("active under supply lockout");
  alarm_a: assert property (input_current_alarm_oe == cs.input_over_ref)
    // RULE_14
    else $error("alarm mismatch");
  period_a: assert property (period_start |=> phase_reg == 8'h00)
    // RULE_18
    else $error("period not restarted");
  bus_gate_a: assert property (!serial_bus_active // RULE_07
    |=> $stable(ctrl_reg) && $stable(duty_reg))
    else $error("write while bus inactive");
  high_c: cover property ($rose(high_gate));
  low_c: cover property ($rose(low_gate) && !sync_mode);
  ovp_c: cover property ($rose(ovp_flag));
  short_c: cover property ($rose(short_flag));
  zero_c: cover property (zero_duty && charging);
endmodule : charger_gate_protect_ctrl

//--- rtl/gate_protect_map.svh
// timing and register map constants for the gate protection controller
`ifndef GATE_PROTECT_MAP_SVH
`define GATE_PROTECT_MAP_SVH
`define CLK_PERIOD_NS 50
`define OSC_FREQ_KHZ 300
`define PERIOD_CYC ((1000000 / `CLK_PERIOD_NS) / `OSC_FREQ_KHZ)
`define DEAD_TIME_NS 30
`define DEAD_CYC ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECHARGE_NS 80
`define RECHARGE_CYC ((`RECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DETECT_DELAY_US 200
`define DETECT_CYC ((`DETECT_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define ADDR_CTRL 12'h000
`define ADDR_DUTY 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_ID 12'h00c
`define CTRL_RESET 32'h0000_0000
`define DUTY_RESET 8'h00
`define DUTY_W 8
// identity value is arbitrary, it names no real part
`define ID_VALUE 32'h0000_5a5a
`endif

//--- rtl/gate_protect_pkg.sv
// types shared by the gate protection controller
package gate_protect_pkg;
  typedef struct packed {
    logic adapter_supply_ok;
    logic adapter_detect_low;
    logic adapter_present;
    logic adapter_above_batt;
    logic serial_bus_supply_ok;
    logic undercurrent;
    logic batt_over_hi;
    logic batt_over_lo;
    logic batt_short_lo;
    logic batt_short_hi;
    logic input_over_ref;
    logic charge_overcurrent;
    logic temp_hi;
    logic temp_lo;
    logic bias_ok;
  } comp_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_HIGH = 3'b001,
    ST_DEAD_HL = 3'b010,
    ST_LOW = 3'b011,
    ST_DEAD_LH = 3'b100
  } drive_state_t;
endpackage : gate_protect_pkg

//--- rtl/hyst_latch.sv
// set/clear hysteresis flag from two threshold comparators
`timescale 1ns/1ns
module hyst_latch (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // thresholds
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag
);
  // set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set_i) begin
      flag <= 1'b1;
    end else if (clr_i) begin
      flag <= 1'b0;
    end
  end
endmodule : hyst_latch

//--- rtl/sync2.sv
// two flip-flop synchroniser, one bit
`timescale 1ns/1ns
module sync2 (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic d,
  output logic q
);
  logic meta_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sync2
